// file: common/ueb_pkg.sv
// Shared definitions for the endpoint 0 error logic and the bulk IN endpoint.
// Assumes a protocol engine on the same clock that reports tokens and packets.
package ueb_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] EP0_CSR_OFS = 8'h00;
  localparam logic [7:0] TX_CSR_OFS = 8'h04;
  localparam logic [7:0] TX_FIFO_SIZE_OFS = 8'h08;
  localparam logic [7:0] TX_MAXP_OFS = 8'h0C;
  localparam logic [7:0] EP0_AUX_OFS = 8'h10;
  localparam logic [7:0] TX_COUNT_OFS = 8'h14;

  // Endpoint 0 control/status fields
  localparam int EP0_RXRDY_BIT = 0;
  localparam int EP0_TXRDY_BIT = 1;
  localparam int EP0_STALLSENT_BIT = 2;
  localparam int EP0_DATA_END_FLAG_BIT = 3;
  localparam int EP0_PREMEND_BIT = 4;
  localparam int EP0_SEND_STALL_REQUEST_BIT = 5;
  localparam int EP0_SERVRX_BIT = 6;
  localparam int EP0_PREMACK_BIT = 7;

  // Endpoint 0 auxiliary fields: state code and IN length
  localparam int AUX_STATE_LSB = 0;
  localparam int AUX_LEN_LSB = 8;

  // Transmit control/status fields, and the FIFO size double-buffer bit
  localparam int TX_RDY_BIT = 0;
  localparam int TX_NONEMPTY_BIT = 1;
  localparam int TX_FLUSH_BIT = 3;
  localparam int TX_SEND_STALL_REQUEST_BIT = 4;
  localparam int TX_STALLSENT_BIT = 5;
  localparam int TX_TOGCLR_BIT = 6;
  localparam int TX_DMA_MODE_SELECT_BIT = 10;
  localparam int TX_FORCETOG_BIT = 11;
  localparam int TX_DMA_REQUEST_ENABLE_BIT = 12;
  localparam int TX_MODE_BIT = 13;
  localparam int TX_ISO_BIT = 14;
  localparam int TX_DPB_BIT = 4;

  // Reset values
  localparam logic [15:0] TX_CFG_RST = 16'h0000;
  localparam logic [10:0] TX_MAXP_RST = 11'h040;
  localparam logic [6:0] EP0_MAXP_RST = 7'h40;
  localparam logic [1:0] PKT_CNT_RST = 2'h0;

  // Link event kinds reported by the protocol engine
  localparam logic [2:0] EV_SETUP = 3'h0;
  localparam logic [2:0] EV_OUT = 3'h1;
  localparam logic [2:0] EV_IN = 3'h2;
  localparam logic [2:0] EV_DATA = 3'h3;
  localparam logic [2:0] EV_ACK = 3'h4;

  // Answer codes handed back to the protocol engine
  localparam logic [1:0] RSP_NAK = 2'h0;
  localparam logic [1:0] RSP_STALL = 2'h1;
  localparam logic [1:0] RSP_DATA = 2'h2;
  localparam logic [1:0] RSP_ACK = 2'h3;

  typedef enum logic [2:0] {
    EP0_IDLE = 3'b001,
    EP0_TX = 3'b010,
    EP0_RX = 3'b100
  } ueb_ep0_e;

  typedef struct packed {
    logic valid;
    logic [2:0] kind;
    logic bulkEp;
    logic dataPid1;
    logic [10:0] count;
  } ueb_evt_s;

  typedef struct packed {
    logic valid;
    logic [1:0] code;
    logic toggle;
    logic [10:0] len;
  } ueb_resp_s;

endpackage

// file: hw/ueb_top.sv
// Endpoint 0 protocol error handling and a bulk IN endpoint, Wishbone slave.
// Assumes the protocol engine shares this clock and gives one event per cycle.
//
// Functional notes
// - OUT token after data end in a control write gets STALL.
// - IN token after data end in a control read gets STALL.
// - Endpoint 0 OUT packet longer than max packet size gets STALL.
// - Non-empty or DATA0 status packet of a control read gets STALL.
// - Every endpoint 0 STALL sets stall-sent bit 2 and interrupts.
// - Early status stage or new SETUP sets premature-end bit 4, interrupts.
// - Software send-stall bit 5 makes the device STALL and interrupt.
// - Early zero-length OUT flushes queued endpoint 0 IN data, flags premature end.
// - Double-buffer enable lets the transmit FIFO hold two packets.
// - With DMA on, request asserted while the FIFO can take a packet.
// - DMA mode bit, with DMA request enable bit 12 set, suppresses per-packet transmit interrupts.
// - Writing toggle-clear bit 6 resets the endpoint data toggle.
// - Bit 1 shows non-empty FIFO; flush bit 3 drops one packet.
// - Transmit-ready clears and interrupts once the packet is sent.
// - With double buffering the first ready packet clears the bit at once.
// - Ready with no data loaded sends a zero-length packet.
// - Send-stall bit 4 makes each IN get STALL while set, bit 5, interrupt.
// - Endpoint 0 state is idle after reset.
// - SETUP, or OUT before data end in transmit phase, is a premature end.
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ueb_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic wbWeI,
  input wire logic [7:0] wbAdrI,
  input wire logic [3:0] wbSelI,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAckO,
  input wire ueb_pkg::ueb_evt_s linkEvt,
  output ueb_pkg::ueb_resp_s linkResp,
  output logic ep0IntPulse,
  output logic txIntPulse,
  output logic dmaReq
);

  // Byte lanes 0 and 1 only; upper lanes hold no bits
  function automatic logic [15:0] laneMask(input logic [3:0] sel);
    laneMask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic busReq;
  logic busWr;
  logic [15:0] wMask;
  logic [15:0] wSet;
  logic wrEp0;
  logic wrTx;
  logic wrFifoSz;
  logic wrMaxp;
  logic wrAux;
  logic wrCount;

  assign busReq = wbCycI & wbStbI & ~wbAckO;
  assign busWr = busReq & wbWeI;
  assign wMask = laneMask(wbSelI);
  assign wSet = wbDatI[15:0] & wMask;
  assign wrEp0 = busWr & (wbAdrI == ueb_pkg::EP0_CSR_OFS);
  assign wrTx = busWr & (wbAdrI == ueb_pkg::TX_CSR_OFS);
  assign wrFifoSz = busWr & (wbAdrI == ueb_pkg::TX_FIFO_SIZE_OFS);
  assign wrMaxp = busWr & (wbAdrI == ueb_pkg::TX_MAXP_OFS);
  assign wrAux = busWr & (wbAdrI == ueb_pkg::EP0_AUX_OFS);
  assign wrCount = busWr & (wbAdrI == ueb_pkg::TX_COUNT_OFS);

  // Bit-clear request: lane selected and written as zero
  function automatic logic zeroWrite(input logic [15:0] mask, input logic [15:0] d,
                                     input int pos);
    zeroWrite = mask[pos] & ~d[pos];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State and storage

  ueb_pkg::ueb_ep0_e ep0State_q;
  ueb_pkg::ueb_ep0_e ep0State_d;
  logic rxRdy_q;
  logic ep0TxRdy_q;
  logic ep0StallSent_q;
  logic data_end_flag_q;
  logic premEnd_q;
  logic ep0SendStall_q;
  logic [6:0] ep0Len_q;
  logic [15:0] txCfg_q;
  logic txStallSent_q;
  logic txToggle_q;
  logic [1:0] pktCnt_q;
  logic headSlot_q;
  logic [10:0] pktLen_q [2];
  logic [10:0] loadCount_q;
  logic [4:0] fifoSize_q;
  logic [10:0] tx_max_packet_q;
  logic lastInBulk_q;

  logic [1:0] pktCap;
  logic txReadyBit;
  assign pktCap = fifoSize_q[ueb_pkg::TX_DPB_BIT] ? 2'h2 : 2'h1;
  assign txReadyBit = (pktCnt_q == pktCap);

  ////////////////////////////////////////////////////////////////////////////
  // Link event decode

  logic evEp0;
  logic evBulk;
  logic ep0Stall;
  logic ep0Prem;
  logic ep0Flush;
  logic ep0GoIdle;
  logic ep0RxSet;
  logic ep0TxDone;
  logic bulkStall;
  logic bulkSent;
  ueb_pkg::ueb_resp_s respNext;

  assign evEp0 = linkEvt.valid & ~linkEvt.bulkEp;
  assign evBulk = linkEvt.valid & linkEvt.bulkEp;

  // Endpoint 0 and bulk IN answers, state changes and flag events for this cycle
  always_comb begin
    ep0Stall = 1'b0;
    ep0Prem = 1'b0;
    ep0Flush = 1'b0;
    ep0GoIdle = 1'b0;
    ep0RxSet = 1'b0;
    ep0TxDone = 1'b0;
    bulkStall = 1'b0;
    bulkSent = 1'b0;
    respNext = '0;
    if (evEp0) begin
      case (linkEvt.kind)
        ueb_pkg::EV_SETUP: begin
          respNext = '{1'b1, ueb_pkg::RSP_ACK, 1'b0, 11'h000};
          ep0RxSet = 1'b1;
          if (ep0State_q != ueb_pkg::EP0_IDLE) begin
            ep0Prem = 1'b1;
            ep0GoIdle = 1'b1;
          end
        end
        ueb_pkg::EV_OUT: begin
          if (ep0SendStall_q) begin
            ep0Stall = 1'b1;
          end else if (ep0State_q == ueb_pkg::EP0_TX && !data_end_flag_q) begin
            ep0Prem = 1'b1;
            ep0GoIdle = 1'b1;
          end else if (ep0State_q == ueb_pkg::EP0_RX && data_end_flag_q) begin
            ep0Stall = 1'b1;
          end
        end
        ueb_pkg::EV_IN: begin
          if (ep0SendStall_q) begin
            ep0Stall = 1'b1;
          end else if (ep0State_q == ueb_pkg::EP0_TX && data_end_flag_q) begin
            ep0Stall = 1'b1;
          end else if (ep0State_q == ueb_pkg::EP0_RX && !data_end_flag_q) begin
            // Early status of a write
            // Still answered, so the host never waits on a silent endpoint
            ep0Prem = 1'b1;
            ep0GoIdle = 1'b1;
            respNext = '{1'b1, ueb_pkg::RSP_NAK, 1'b0, 11'h000};
          end else if (ep0State_q == ueb_pkg::EP0_RX) begin
            respNext = '{1'b1, ueb_pkg::RSP_DATA, 1'b1, 11'h000};
          end else if (ep0State_q == ueb_pkg::EP0_TX && ep0TxRdy_q) begin
            respNext = '{1'b1, ueb_pkg::RSP_DATA, 1'b0, {4'h0, ep0Len_q}};
          end else begin
            respNext = '{1'b1, ueb_pkg::RSP_NAK, 1'b0, 11'h000};
          end
        end
        ueb_pkg::EV_DATA: begin
          if (linkEvt.count > {4'h0, ueb_pkg::EP0_MAXP_RST}) begin
            ep0Stall = 1'b1;
          end else if (ep0State_q == ueb_pkg::EP0_TX && data_end_flag_q) begin
            // Bad status packet of a read
            if (linkEvt.count != 11'h000 || !linkEvt.dataPid1) begin
              ep0Stall = 1'b1;
            end else begin
              respNext = '{1'b1, ueb_pkg::RSP_ACK, 1'b0, 11'h000};
              ep0GoIdle = 1'b1;
            end
          end else if (ep0State_q == ueb_pkg::EP0_TX && linkEvt.count == 11'h000) begin
            ep0Flush = 1'b1;
            ep0Prem = 1'b1;
            ep0GoIdle = 1'b1;
            respNext = '{1'b1, ueb_pkg::RSP_ACK, 1'b0, 11'h000};
          end else if (rxRdy_q) begin
            respNext = '{1'b1, ueb_pkg::RSP_NAK, 1'b0, 11'h000};
          end else begin
            respNext = '{1'b1, ueb_pkg::RSP_ACK, 1'b0, 11'h000};
            ep0RxSet = 1'b1;
          end
        end
        ueb_pkg::EV_ACK: begin
          if (!lastInBulk_q && ep0State_q == ueb_pkg::EP0_RX && data_end_flag_q) begin
            ep0GoIdle = 1'b1;
          end else if (!lastInBulk_q) begin
            ep0TxDone = 1'b1;
          end
        end
        default: begin
          respNext = '0;
        end
      endcase
      if (ep0Stall) begin
        respNext = '{1'b1, ueb_pkg::RSP_STALL, 1'b0, 11'h000};
        ep0GoIdle = 1'b1;
      end
    end else if (evBulk && linkEvt.kind == ueb_pkg::EV_IN) begin
      if (txCfg_q[ueb_pkg::TX_SEND_STALL_REQUEST_BIT]) begin
        bulkStall = 1'b1;
        respNext = '{1'b1, ueb_pkg::RSP_STALL, 1'b0, 11'h000};
      end else if (pktCnt_q != 2'h0) begin
        respNext = '{1'b1, ueb_pkg::RSP_DATA, txToggle_q, pktLen_q[headSlot_q]};
        bulkSent = txCfg_q[ueb_pkg::TX_FORCETOG_BIT];
      end else begin
        respNext = '{1'b1, ueb_pkg::RSP_NAK, 1'b0, 11'h000};
      end
    end else if (evBulk && linkEvt.kind == ueb_pkg::EV_ACK) begin
      // Forced toggle already retired the packet when it went out
      bulkSent = lastInBulk_q & (pktCnt_q != 2'h0) & ~txCfg_q[ueb_pkg::TX_FORCETOG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Endpoint 0 state and flags

  // Idle from reset; software picks data phase
  always_comb begin
    ep0State_d = ep0State_q;
    if (wrAux && wMask[0]) begin
      case (wbDatI[ueb_pkg::AUX_STATE_LSB +: 2])
        2'h1: ep0State_d = ueb_pkg::EP0_TX;
        2'h2: ep0State_d = ueb_pkg::EP0_RX;
        default: ep0State_d = ueb_pkg::EP0_IDLE;
      endcase
    end
    if (ep0GoIdle) begin
      ep0State_d = ueb_pkg::EP0_IDLE;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ep0State_q <= ueb_pkg::EP0_IDLE;
    end else if (clkEn) begin
      ep0State_q <= ep0State_d;
    end
  end

  // Flags set by the link win over a same-cycle software clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxRdy_q <= 1'b0;
      ep0StallSent_q <= 1'b0;
      premEnd_q <= 1'b0;
    end else if (clkEn) begin
      rxRdy_q <= ep0RxSet | (rxRdy_q & ~(wrEp0 & wSet[ueb_pkg::EP0_SERVRX_BIT]));
      // Stall-sent on every endpoint 0 STALL
      ep0StallSent_q <= ep0Stall |
                        (ep0StallSent_q &
                         ~(wrEp0 & zeroWrite(wMask, wbDatI[15:0], ueb_pkg::EP0_STALLSENT_BIT)));
      premEnd_q <= ep0Prem | (premEnd_q & ~(wrEp0 & wSet[ueb_pkg::EP0_PREMACK_BIT]));
    end
  end

  // Software-set bits the link retires
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ep0TxRdy_q <= 1'b0;
      data_end_flag_q <= 1'b0;
      ep0SendStall_q <= 1'b0;
      ep0Len_q <= '0;
    end else if (clkEn) begin
      if (ep0Flush || ep0TxDone || ep0GoIdle) begin
        ep0TxRdy_q <= 1'b0;
      end else if (wrEp0 && wSet[ueb_pkg::EP0_TXRDY_BIT]) begin
        ep0TxRdy_q <= 1'b1;
      end
      if (ep0GoIdle) begin
        data_end_flag_q <= 1'b0;
      end else if (wrEp0 && wSet[ueb_pkg::EP0_DATA_END_FLAG_BIT]) begin
        data_end_flag_q <= 1'b1;
      end
      // Request held until the STALL goes out
      if (ep0Stall) begin
        ep0SendStall_q <= 1'b0;
      end else if (wrEp0 && wSet[ueb_pkg::EP0_SEND_STALL_REQUEST_BIT]) begin
        ep0SendStall_q <= 1'b1;
      end
      if (wrAux && wMask[8]) begin
        ep0Len_q <= wbDatI[ueb_pkg::AUX_LEN_LSB +: 7];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bulk IN configuration

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txCfg_q <= ueb_pkg::TX_CFG_RST;
      fifoSize_q <= '0;
      tx_max_packet_q <= ueb_pkg::TX_MAXP_RST;
      loadCount_q <= '0;
    end else if (clkEn) begin
      if (wrTx) begin
        txCfg_q <= (txCfg_q & ~wMask) | (wbDatI[15:0] & wMask & 16'h7C10);
      end
      if (wrFifoSz && wMask[0]) begin
        fifoSize_q <= wbDatI[4:0];
      end
      if (wrMaxp) begin
        tx_max_packet_q <= (tx_max_packet_q & ~wMask[10:0]) | (wbDatI[10:0] & wMask[10:0]);
      end
      if (wrCount) begin
        loadCount_q <= (loadCount_q & ~wMask[10:0]) | (wbDatI[10:0] & wMask[10:0]);
      end
    end
  end

  // Stall-sent set by the link, cleared by writing zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txStallSent_q <= 1'b0;
    end else if (clkEn) begin
      txStallSent_q <= bulkStall |
                       (txStallSent_q &
                        ~(wrTx & zeroWrite(wMask, wbDatI[15:0], ueb_pkg::TX_STALLSENT_BIT)));
    end
  end

  // Data toggle flips on each retired packet
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txToggle_q <= 1'b0;
    end else if (clkEn) begin
      if (wrTx && wSet[ueb_pkg::TX_TOGCLR_BIT]) begin
        txToggle_q <= 1'b0;
      end else if (bulkSent) begin
        txToggle_q <= ~txToggle_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet slots

  logic loadPkt;
  logic dropPkt;
  assign loadPkt = wrTx & wSet[ueb_pkg::TX_RDY_BIT] & (pktCnt_q < pktCap);
  assign dropPkt = bulkSent | (wrTx & wSet[ueb_pkg::TX_FLUSH_BIT] & (pktCnt_q != 2'h0));

  // Length recorded per slot; lengths stand in for the FIFO contents
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pktCnt_q <= ueb_pkg::PKT_CNT_RST;
      headSlot_q <= 1'b0;
      pktLen_q[0] <= '0;
      pktLen_q[1] <= '0;
    end else if (clkEn) begin
      pktCnt_q <= pktCnt_q + {1'b0, loadPkt} - {1'b0, dropPkt};
      if (dropPkt) begin
        headSlot_q <= ~headSlot_q;
      end
      if (loadPkt) begin
        // Tail slot is head plus count, whether or not the head retires now
        pktLen_q[headSlot_q ^ (pktCnt_q != 2'h0)] <= loadCount_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link answer, interrupt pulses, DMA request

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      linkResp <= '0;
      lastInBulk_q <= 1'b0;
    end else if (clkEn) begin
      linkResp <= respNext;
      if (linkEvt.valid && linkEvt.kind == ueb_pkg::EV_IN) begin
        lastInBulk_q <= linkEvt.bulkEp;
      end
    end
  end

  logic ep0IntEvt;
  logic txIntEvt;
  logic dmaQuiet;
  assign ep0IntEvt = ep0Stall | ep0Prem | ep0RxSet | ep0TxDone;
  // DMA mode keeps only error interrupts
  assign dmaQuiet = txCfg_q[ueb_pkg::TX_DMA_REQUEST_ENABLE_BIT] & txCfg_q[ueb_pkg::TX_DMA_MODE_SELECT_BIT];
  // Sent packet frees a slot and interrupts
  // Ready cleared at once when a slot stays free
  assign txIntEvt = bulkStall |
                    (~dmaQuiet & (bulkSent | (loadPkt & (pktCnt_q + 2'h1 < pktCap))));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ep0IntPulse <= 1'b0;
      txIntPulse <= 1'b0;
      dmaReq <= 1'b0;
    end else if (clkEn) begin
      ep0IntPulse <= ep0IntEvt;
      txIntPulse <= txIntEvt;
      // Request while a slot is free
      dmaReq <= txCfg_q[ueb_pkg::TX_DMA_REQUEST_ENABLE_BIT] &
                ((pktCnt_q + {1'b0, loadPkt} - {1'b0, dropPkt}) < pktCap);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and acknowledge

  logic [15:0] rdData;
  always_comb begin
    rdData = 16'h0000;
    case (wbAdrI)
      ueb_pkg::EP0_CSR_OFS: begin
        rdData[ueb_pkg::EP0_RXRDY_BIT] = rxRdy_q;
        rdData[ueb_pkg::EP0_TXRDY_BIT] = ep0TxRdy_q;
        rdData[ueb_pkg::EP0_STALLSENT_BIT] = ep0StallSent_q;
        rdData[ueb_pkg::EP0_DATA_END_FLAG_BIT] = data_end_flag_q;
        rdData[ueb_pkg::EP0_PREMEND_BIT] = premEnd_q;
        rdData[ueb_pkg::EP0_SEND_STALL_REQUEST_BIT] = ep0SendStall_q;
      end
      ueb_pkg::TX_CSR_OFS: begin
        rdData = txCfg_q;
        rdData[ueb_pkg::TX_RDY_BIT] = txReadyBit;
        rdData[ueb_pkg::TX_NONEMPTY_BIT] = (pktCnt_q != 2'h0);
        rdData[ueb_pkg::TX_STALLSENT_BIT] = txStallSent_q;
      end
      ueb_pkg::TX_FIFO_SIZE_OFS: rdData = {11'h000, fifoSize_q};
      ueb_pkg::TX_MAXP_OFS: rdData = {5'h00, tx_max_packet_q};
      ueb_pkg::EP0_AUX_OFS: begin
        rdData = {1'b0, ep0Len_q, 3'h0, txToggle_q, 2'h0,
                  ep0State_q == ueb_pkg::EP0_RX, ep0State_q == ueb_pkg::EP0_TX};
      end
      ueb_pkg::TX_COUNT_OFS: rdData = {5'h00, loadCount_q};
      default: rdData = 16'h0000;
    endcase
  end

  // One wait state; unmapped reads answer zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wbAckO <= 1'b0;
      wbDatO <= '0;
    end else if (clkEn) begin
      wbAckO <= busReq;
      wbDatO <= {16'h0000, rdData};
    end
  end

endmodule

`default_nettype wire

// file: tb/ueb_checker.sv
// Port checker for the endpoint block.
// Assumes one clock domain and the active-low async reset.
`timescale 1ns/1ps
`default_nettype none
module ueb_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic wbCycI,
  input wire logic wbStbI,
  input wire logic wbWeI,
  input wire logic [7:0] wbAdrI,
  input wire logic [3:0] wbSelI,
  input wire logic [31:0] wbDatI,
  input wire logic [31:0] wbDatO,
  input wire logic wbAckO,
  input wire ueb_pkg::ueb_evt_s linkEvt,
  input wire ueb_pkg::ueb_resp_s linkResp,
  input wire logic ep0IntPulse,
  input wire logic txIntPulse,
  input wire logic dmaReq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////
  // Bus answers exactly one cycle after a taken request
  a_ack_next:
    assert property (wbCycI && wbStbI && !wbAckO |=> wbAckO) else $error("ack late");
  a_ack_pulse:
    assert property (wbAckO |=> !wbAckO) else $error("ack too long");
  a_ack_cause:
    assert property (wbAckO |-> $past(wbCycI && wbStbI)) else $error("ack unasked");
  a_read_high:
    assert property (wbAckO |-> wbDatO[31:16] == 16'h0000) else $error("upper half set");
  // Every IN token is answered the next cycle
  a_in_answer:
    assert property (linkEvt.valid && linkEvt.kind == ueb_pkg::EV_IN |=> linkResp.valid)
      else $error("IN unanswered");
  // Stall answers come with their interrupt
  a_ep0_stall:
    assert property ($past(linkEvt.valid && !linkEvt.bulkEp) && linkResp.valid
      && linkResp.code == ueb_pkg::RSP_STALL |-> ep0IntPulse) else $error("ep0 stall quiet");
  a_bulk_stall:
    assert property ($past(linkEvt.valid && linkEvt.bulkEp) && linkResp.valid
      && linkResp.code == ueb_pkg::RSP_STALL |-> txIntPulse) else $error("bulk stall quiet");
  a_big_out:
    assert property (linkEvt.valid && !linkEvt.bulkEp && linkEvt.kind == ueb_pkg::EV_DATA
      && linkEvt.count > {4'h0, ueb_pkg::EP0_MAXP_RST}
      |=> linkResp.valid && linkResp.code == ueb_pkg::RSP_STALL) else $error("long OUT taken");
  a_reset_quiet:
    assert property ($rose(rstn) |-> !ep0IntPulse && !txIntPulse && !dmaReq)
      else $error("busy after reset");
  // Main scenarios seen
  cover property (linkResp.valid && linkResp.code == ueb_pkg::RSP_STALL);
  cover property (txIntPulse);
  cover property (dmaReq);
endmodule
bind ueb_top ueb_checker u_chk (.clock(clock), .rstn(rstn), .clkEn(clkEn),
  .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI),
  .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO), .linkEvt(linkEvt),
  .linkResp(linkResp), .ep0IntPulse(ep0IntPulse), .txIntPulse(txIntPulse), .dmaReq(dmaReq));
`default_nettype wire

// file: tb/ueb_host_model.sv
// Host side model: issues tokens and packets one at a time.
// Assumes the protocol engine shares the block clock.
`timescale 1ns/1ps
`default_nettype none
module ueb_host_model (
  input wire logic clock,
  output var ueb_pkg::ueb_evt_s evt
);
  initial evt = '0;
  //////////////////////////////////////////
  // One event for one cycle, then room for the answer
  task automatic send(input logic [2:0] k, input logic b, input logic p,
    input logic [10:0] c);
    @(posedge clock);
    evt <= '{1'b1, k, b, p, c};
    @(posedge clock);
    // Idle fields show the inverse, so stale values never pass
    evt <= '{1'b0, ~k, ~b, ~p, ~c};
    repeat (2) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// file: tb/ueb_tb_top.sv
// Self-checking bench: Wishbone register calls and host events.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ueb_tb_top;
  localparam logic [7:0] C0 = ueb_pkg::EP0_CSR_OFS;
  localparam logic [7:0] TC = ueb_pkg::TX_CSR_OFS;
  localparam logic [7:0] FS = ueb_pkg::TX_FIFO_SIZE_OFS;
  localparam logic [7:0] AX = ueb_pkg::EP0_AUX_OFS;
  localparam logic [7:0] CN = ueb_pkg::TX_COUNT_OFS;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic wbCycI, wbStbI, wbWeI, wbAckO, ep0IntPulse, txIntPulse, dmaReq;
  logic [7:0] wbAdrI;
  logic [3:0] wbSelI;
  logic [31:0] wbDatI, wbDatO;
  logic [15:0] q;
  logic [31:0] e;
  ueb_pkg::ueb_evt_s linkEvt;
  ueb_pkg::ueb_resp_s linkResp, rsp;
  int failures = 0;
  int check_count = 0;
  int ep0N = 0, txN = 0, rspN = 0, e0, t, r;
  initial begin
    forever #10 clock = ~clock;
  end
  ueb_top DUT (.clock(clock), .rstn(rstn), .clkEn(1'b1), .wbCycI(wbCycI),
    .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAckO(wbAckO), .linkEvt(linkEvt), .linkResp(linkResp),
    .ep0IntPulse(ep0IntPulse), .txIntPulse(txIntPulse), .dmaReq(dmaReq));
  ueb_host_model host (.clock(clock), .evt(linkEvt));
  // Count interrupt pulses and keep the last answer
  always @(posedge clock) begin
    if (ep0IntPulse === 1'b1) ep0N <= ep0N + 1;
    if (txIntPulse === 1'b1) txN <= txN + 1;
    if (linkResp.valid === 1'b1) begin
      rsp <= linkResp;
      rspN <= rspN + 1;
    end
  end
  //////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    check_count++;
    if (g !== x) begin
      failures++;
      $display("FAIL t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic results();
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Classic single cycle; held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbWeI <= w;
    wbAdrI <= a;
    wbDatI <= {16'h0000, d};
    wbSelI <= 4'h3;
    do begin
      @(posedge clock);
      n++;
    end while (wbAckO !== 1'b1 && n < 20);
    q = wbDatO[15:0];
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
    if (n >= 20) begin
      failures++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rb(input logic [7:0] a, input logic [15:0] m, input logic [15:0] x);
    xfer(1'b0, a, 16'h0000);
    chk(q & m, x);
  endtask
  task automatic ev(input logic [2:0] k, input logic b, input logic p, input logic [10:0] c);
    e0 = ep0N;
    t = txN;
    r = rspN;
    host.send(k, b, p, c);
  endtask
  task automatic stall(input int ei, input int ti);
    chk(rspN - r, 1);
    chk(rsp.code, ueb_pkg::RSP_STALL);
    chk(ep0N - e0, ei);
    chk(txN - t, ti);
  endtask
  // Endpoint 0 stall cases: aux state, csr, kind, pid, count
  logic [31:0] tab [6] = '{32'h2081_0000, 32'h1082_0000, 32'h2003_1041,
    32'h1083_1003, 32'h1083_0000, 32'h0202_0000};
  //////////////////////////////////////////
  initial begin
    wbCycI = 1'b0;
    wbStbI = 1'b0;
    wbWeI = 1'b0;
    wbAdrI = 8'h00;
    wbSelI = 4'h0;
    wbDatI = 32'h0000_0000;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    rb(ueb_pkg::TX_MAXP_OFS, 16'hFFFF, {5'h00, ueb_pkg::TX_MAXP_RST});
    rb(TC, 16'hFFFF, ueb_pkg::TX_CFG_RST);
    rb(C0, 16'hFFFF, 16'h0000);
    rb(AX, 16'h0003, 16'h0000);
    rb(8'h1C, 16'hFFFF, 16'h0000);
    foreach (tab[i]) begin
      e = tab[i];
      wr(AX, {12'h000, e[31:28]});
      wr(C0, {8'h00, e[27:20]});
      ev(e[18:16], 1'b0, e[12], e[10:0]);
      stall(1, 0);
      rb(C0, 16'h002C, 16'h0004);
      rb(AX, 16'h0003, 16'h0000);
      wr(C0, 16'h0000);
    end
    // Early OUT token or new SETUP in transmit phase, early IN in receive phase
    for (int i = 0; i < 3; i++) begin
      wr(AX, (i == 2) ? 16'h0002 : 16'h0001);
      ev((i == 2) ? ueb_pkg::EV_IN : (i ? ueb_pkg::EV_SETUP : ueb_pkg::EV_OUT),
        1'b0, 1'b0, 11'h000);
      chk(ep0N > e0, 1'b1);
      rb(C0, 16'h0011, (i == 1) ? 16'h0011 : 16'h0010);
      wr(C0, 16'h00C0);
      rb(C0, 16'h0091, 16'h0000);
      wr(AX, 16'h0000);
    end
    wr(AX, 16'h0001);
    wr(C0, 16'h0002);
    ev(ueb_pkg::EV_DATA, 1'b0, 1'b1, 11'h000);
    rb(C0, 16'h0012, 16'h0010);
    wr(C0, 16'h0080);
    wr(AX, 16'h0000);
    // Double buffering, then flushing twice
    wr(FS, 16'h0010);
    wr(CN, 16'h0008);
    t = txN;
    wr(TC, 16'h0001);
    rb(TC, 16'h0003, 16'h0002);
    chk(txN - t, 1);
    wr(TC, 16'h0001);
    rb(TC, 16'h0003, 16'h0003);
    wr(TC, 16'h0008);
    rb(TC, 16'h0003, 16'h0002);
    wr(TC, 16'h0008);
    rb(TC, 16'h0003, 16'h0000);
    // Single buffer: null packet, toggle flip and clear
    wr(FS, 16'h0000);
    wr(TC, 16'h0040);
    rb(AX, 16'h0010, 16'h0000);
    wr(CN, 16'h0000);
    wr(TC, 16'h0001);
    ev(ueb_pkg::EV_IN, 1'b1, 1'b0, 11'h000);
    chk({rsp.code, rsp.toggle, rsp.len}, {ueb_pkg::RSP_DATA, 1'b0, 11'h000});
    ev(ueb_pkg::EV_ACK, 1'b1, 1'b0, 11'h000);
    chk(txN - t, 1);
    rb(TC, 16'h0003, 16'h0000);
    rb(AX, 16'h0010, 16'h0010);
    wr(TC, 16'h0040);
    rb(AX, 16'h0010, 16'h0000);
    // DMA with per-packet interrupts suppressed
    wr(TC, 16'h3400);
    rb(TC, 16'h7C00, 16'h3400);
    chk(dmaReq, 1'b1);
    wr(CN, 16'h0008);
    wr(TC, 16'h3401);
    rb(TC, 16'h0003, 16'h0003);
    chk(dmaReq, 1'b0);
    ev(ueb_pkg::EV_IN, 1'b1, 1'b0, 11'h000);
    chk({rsp.code, rsp.toggle, rsp.len}, {ueb_pkg::RSP_DATA, 1'b0, 11'h008});
    ev(ueb_pkg::EV_ACK, 1'b1, 1'b0, 11'h000);
    chk(txN - t, 0);
    chk(dmaReq, 1'b1);
    // Bulk stall kept while the host retries
    wr(TC, 16'h0010);
    ev(ueb_pkg::EV_IN, 1'b1, 1'b0, 11'h000);
    stall(0, 1);
    rb(TC, 16'h0030, 16'h0030);
    wr(TC, 16'h0010);
    rb(TC, 16'h0030, 16'h0010);
    ev(ueb_pkg::EV_IN, 1'b1, 1'b0, 11'h000);
    stall(0, 1);
    wr(TC, 16'h0040);
    results();
  end
endmodule
`default_nettype wire
